/* rtl/smc_bus_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface smc_bus_if;
	logic scl;
	logic rst_pin;
	logic sda_host_o;
	logic sda_host_oe;
	logic sda_dev_o;
	logic sda_dev_oe;
	wire  sda = !((sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o));
	modport dev (input scl, input rst_pin, input sda, output sda_dev_o, output sda_dev_oe);
	modport host (output scl, output rst_pin, input sda, output sda_host_o, output sda_host_oe);
endinterface : smc_bus_if
`default_nettype wire

/* rtl/smc_device.sv */
`timescale 1ns/1ps
`default_nettype none
module smc_device #(
	parameter int          T_WR      = smc_pkg::T_WR_CYCLES,
	parameter logic [31:0] ATR_VALUE = 32'h3b_b2_11_00,  // arbitrary
	parameter logic [23:0] SECURE    = 24'h000000,
	parameter logic [63:0] SEED      = 64'h0
) (
	input  wire logic clk,
	input  wire logic rst,
	smc_bus_if.dev    bus,
	output logic      standby,
	output logic      busy,
	output logic [2:0] fuses,
	output logic      auth_ok,
	output logic      pw_ok
);
	// ****************************************
	// line sampling
	// ****************************************
	logic scl_q, sda_q, rpin_q;
	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			scl_q <= 1'b0;
			sda_q <= 1'b1;
			rpin_q <= 1'b0;
		end
		else
		begin
			scl_q <= bus.scl;
			sda_q <= bus.sda;
			rpin_q <= bus.rst_pin;
		end
	wire scl_rise = bus.scl && !scl_q;
	wire scl_fall = !bus.scl && scl_q;
	wire start_ev = bus.scl && scl_q && sda_q && !bus.sda;
	wire stop_ev  = bus.scl && scl_q && !sda_q && bus.sda;

	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001, ST_RX = 6'b000010, ST_ACK = 6'b000100,
		ST_TX = 6'b001000, ST_TXACK = 6'b010000, ST_ATR = 6'b100000
	} smc_dev_st_t;
	smc_dev_st_t st;
	logic [7:0] sh, cmd, pw_cnt, auth_cnt;
	logic [3:0] bitn, nbyte, sel;
	logic [5:0] atr_n;
	logic [23:0] pw;
	logic [63:0] chal, crypt, rng;
	logic inited, pend, nop, ign;
	logic [$clog2(T_WR+1)-1:0] wr_cnt;
	wire pw_match = pw == SECURE;
	// only a frame of its full length starts a cycle; a bare poll must not
	wire cmd_complete = (cmd == smc_pkg::CMD_FUSE_WR && nbyte == 4'h1)
		|| (cmd == smc_pkg::CMD_VERIFY_PW && nbyte == 4'h5)
		|| ((cmd == smc_pkg::CMD_INIT_AUTH || cmd == smc_pkg::CMD_VERIFY_AUTH) && nbyte == 4'h9);

	// ****************************************
	// protocol engine
	// ****************************************
	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			st <= ST_IDLE;
			sh <= 8'h00;
			cmd <= 8'h00;
			bitn <= 4'h0;
			nbyte <= 4'h0;
			sel <= 4'h0;
			pw <= 24'h0;
			chal <= 64'h0;
			atr_n <= 6'h0;
			bus.sda_dev_o <= 1'b1;
			bus.sda_dev_oe <= 1'b0;
			pend <= 1'b0;
			ign <= 1'b0;
		end
		else
		begin
			pend <= 1'b0;
			if (rpin_q && scl_rise)
			begin
				// reset pulse loads bit 0, data pulses follow lsb first
				st <= ST_ATR;
				atr_n <= 6'h0;
				bus.sda_dev_oe <= 1'b1;
				bus.sda_dev_o <= ATR_VALUE[0];
			end
			else if (start_ev)
			begin
				st <= ST_RX;
				bitn <= 4'h0;
				nbyte <= 4'h0;
				ign <= 1'b0;
				bus.sda_dev_oe <= 1'b0;
			end
			else if (stop_ev)
			begin
				st <= ST_IDLE;
				bus.sda_dev_oe <= 1'b0;
				pend <= !ign && !busy && cmd_complete;
			end
			else
				unique case (st)
					ST_IDLE:
					begin
					end
					ST_ATR:
						if (scl_rise)
							atr_n <= atr_n + 6'h1;
						else if (scl_fall && atr_n == 6'(smc_pkg::ATR_BITS))
						begin
							st <= ST_IDLE;
							bus.sda_dev_oe <= 1'b0;
						end
						else if (scl_fall && atr_n != 6'h0)
							bus.sda_dev_o <= ATR_VALUE[atr_n[4:0]];
					ST_RX:
						if (scl_rise)
						begin
							sh <= {sh[6:0], bus.sda};
							bitn <= bitn + 4'h1;
						end
						else if (scl_fall && bitn == 4'h8)
						begin
							// no ack while a write cycle runs
							if (busy)
							begin
								st <= ST_IDLE;
								ign <= 1'b1;
							end
							else
							begin
								st <= ST_ACK;
								bus.sda_dev_oe <= 1'b1;
								bus.sda_dev_o <= 1'b0;
								if (nbyte == 4'h0)
									cmd <= sh;
								else if (cmd == smc_pkg::CMD_VERIFY_PW && nbyte == 4'h1)
									sel <= sh[3:0];
								else if (cmd == smc_pkg::CMD_VERIFY_PW)
									pw <= {pw[15:0], sh};
								else
									chal <= {chal[55:0], sh};
								nbyte <= nbyte + 4'h1;
							end
						end
					ST_ACK:
						if (scl_fall)
						begin
							bitn <= 4'h0;
							if (cmd == smc_pkg::CMD_FUSE_RD && nbyte == 4'h1)
							begin
								st <= ST_TX;
								sh <= {5'h1f, fuses} << 1;
								bus.sda_dev_o <= fuses[2];
								bitn <= 4'h1;
							end
							else
							begin
								st <= ST_RX;
								bus.sda_dev_oe <= 1'b0;
							end
						end
					ST_TX:
						if (scl_fall)
						begin
							if (bitn == 4'h8)
							begin
								st <= ST_TXACK;
								bus.sda_dev_oe <= 1'b0;
							end
							else
							begin
								bus.sda_dev_o <= sh[7];
								sh <= {sh[6:0], 1'b1};
								bitn <= bitn + 4'h1;
							end
						end
					ST_TXACK:
						if (scl_rise)
							st <= ST_IDLE;  // one byte only, then wait
					default:
						st <= ST_IDLE;
				endcase
		end

	// ****************************************
	// nonvolatile cycle and security state
	// ****************************************
	wire pw_cnt_live   = pw_cnt != smc_pkg::CNT_DEAD;
	wire auth_cnt_live = auth_cnt != smc_pkg::CNT_DEAD;
	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			busy <= 1'b0;
			wr_cnt <= '0;
			fuses <= smc_pkg::FUSES_RESET;
			pw_cnt <= smc_pkg::CNT_FULL;
			auth_cnt <= smc_pkg::CNT_FULL;
			crypt <= 64'h0;
			rng <= 64'h0;
			inited <= 1'b0;
			nop <= 1'b0;
		end
		else if (busy)
		begin
			wr_cnt <= wr_cnt - 1'b1;
			if (wr_cnt == 1)
				busy <= 1'b0;
		end
		else if (pend)
		begin
			busy <= 1'b1;
			wr_cnt <= ($bits(wr_cnt))'(T_WR);
			unique case (cmd)
				smc_pkg::CMD_FUSE_WR:
					if (pw_ok)  // fuses only ever clear
					begin
						if (fuses[2])
							fuses[2] <= 1'b0;
						else if (fuses[1])
							fuses[1] <= 1'b0;
						else if (fuses[0])
							fuses[0] <= 1'b0;
						else
							busy <= 1'b0;  // all blown, cancelled
					end
					else
						busy <= 1'b0;
				smc_pkg::CMD_VERIFY_PW:
					if (pw_cnt_live)
						pw_cnt <= pw_match ? smc_pkg::CNT_FULL : (pw_cnt << 1);
				smc_pkg::CMD_INIT_AUTH:
					if (auth_cnt_live)
					begin
						rng <= crypt ^ SEED ^ chal;
						auth_cnt <= auth_cnt << 1;
						inited <= 1'b1;
					end
				smc_pkg::CMD_VERIFY_AUTH:
					if (auth_cnt_live && inited)
					begin
						inited <= 1'b0;
						if (chal == crypt + 64'h1)
						begin
							crypt <= crypt + 64'h2;
							auth_cnt <= smc_pkg::CNT_FULL;
						end
					end
				default:
					busy <= 1'b0;
			endcase
		end
	// rights tied to the last presentation; pin reset revokes them
	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			pw_ok <= 1'b0;
			auth_ok <= 1'b0;
		end
		else if (rpin_q)
		begin
			pw_ok <= 1'b0;
			auth_ok <= 1'b0;
		end
		else if (pend && cmd == smc_pkg::CMD_VERIFY_PW && pw_cnt_live)
			pw_ok <= pw_match && sel == smc_pkg::SEL_SECURE;
		else if (pend && cmd == smc_pkg::CMD_INIT_AUTH)
			auth_ok <= 1'b0;
		else if (pend && cmd == smc_pkg::CMD_VERIFY_AUTH && auth_cnt_live)
			auth_ok <= inited && chal == crypt + 64'h1;
	always_ff @(posedge clk or posedge rst)
		if (rst)
			standby <= 1'b1;
		else
			standby <= st == ST_IDLE && !busy && !pend;
endmodule : smc_device
`default_nettype wire

/* rtl/smc_host.sv */
`timescale 1ns/1ps
`default_nettype none
module smc_host (
	input  wire logic       clk,
	input  wire logic       rst,
	smc_bus_if.host         bus,
	input  wire logic       go,
	input  wire logic [7:0] cmd,
	input  wire logic [7:0] data [0:8],
	input  wire logic [3:0] nbytes,
	input  wire logic       do_read,
	input  wire logic       do_atr,
	output logic            done,
	output logic            nacked,
	output logic [31:0]     rx
);
	typedef enum logic [3:0] {
		H_IDLE = 4'b0001, H_START = 4'b0010, H_BITS = 4'b0100, H_STOP = 4'b1000
	} smc_host_st_t;
	smc_host_st_t st;
	logic [3:0] bi, byt;
	logic [2:0] ph;
	logic [5:0] atr_n;
	logic atr;
	wire [7:0] cur = byt == 4'h0 ? cmd : data[byt - 4'h1];
	wire rd_phase = do_read && byt == nbytes;

	// ****************************************
	// bit engine, five phases per clock
	// ****************************************
	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			st <= H_IDLE;
			bus.scl <= 1'b0;
			bus.rst_pin <= 1'b0;
			bus.sda_host_o <= 1'b1;
			bus.sda_host_oe <= 1'b0;
			bi <= 4'h0;
			byt <= 4'h0;
			ph <= 3'h0;
			atr <= 1'b0;
			atr_n <= 6'h0;
			done <= 1'b0;
			nacked <= 1'b0;
			rx <= 32'h0;
		end
		else
		begin
			done <= 1'b0;
			ph <= ph + 3'h1;
			unique case (st)
				H_IDLE:
				begin
					ph <= 3'h0;
					if (go)
					begin
						atr <= do_atr;
						atr_n <= 6'h0;
						bus.rst_pin <= do_atr;
						bus.sda_host_oe <= 1'b0;
						byt <= 4'h0;
						bi <= 4'h0;
						nacked <= 1'b0;
						st <= do_atr ? H_BITS : H_START;
					end
				end
				H_START:
					if (ph == 3'h1)
						bus.scl <= 1'b1;
					else if (ph == 3'h3)
					begin
						bus.sda_host_oe <= 1'b1;
						bus.sda_host_o <= 1'b0;
					end
					else if (ph == 3'h5)
					begin
						bus.sda_host_o <= 1'b0;
						bus.scl <= 1'b0;
						ph <= 3'h0;
						st <= H_BITS;
					end
				H_BITS:
					if (ph == 3'h0)
					begin
						// data set up only while scl low
						if (atr || bi == 4'h8)
							bus.sda_host_oe <= !atr && rd_phase;
						else if (rd_phase)
							bus.sda_host_oe <= 1'b0;
						else
						begin
							bus.sda_host_oe <= !cur[3'(7 - bi)];
							bus.sda_host_o <= 1'b0;
						end
					end
					else if (ph == 3'h2)
						bus.scl <= 1'b1;
					else if (ph == 3'h3)
					begin
						if (atr)
						begin
							// the reset pulse itself carries no data bit
							if (atr_n != 6'h0)
								rx <= {bus.sda, rx[31:1]};  // lsb first
							bus.rst_pin <= 1'b0;
						end
						else if (bi == 4'h8 && !rd_phase && bus.sda)
							nacked <= 1'b1;  // no ack: device busy with a write cycle
						else if (bi != 4'h8 && rd_phase)
							rx <= {rx[23:0], bus.sda};
					end
					else if (ph == 3'h4)
					begin
						bus.scl <= 1'b0;
						ph <= 3'h0;
						if (atr)
						begin
							atr_n <= atr_n + 6'h1;
							if (atr_n == 6'(smc_pkg::ATR_BITS))
								st <= H_IDLE;
							if (atr_n == 6'(smc_pkg::ATR_BITS))
								done <= 1'b1;
						end
						else if (bi == 4'h8)
						begin
							bi <= 4'h0;
							byt <= byt + 4'h1;
							// ack the read byte, then stop to end it
							if (nacked || rd_phase || (byt == nbytes - 4'h1 && !do_read))
								st <= H_STOP;
						end
						else
							bi <= bi + 4'h1;
					end
				H_STOP:
					// sda rises while scl high; scl left low after
					if (ph == 3'h1)
					begin
						bus.sda_host_oe <= 1'b1;
						bus.sda_host_o <= 1'b0;
					end
					else if (ph == 3'h2)
						bus.scl <= 1'b1;
					else if (ph == 3'h4)
						bus.sda_host_oe <= 1'b0;
					else if (ph == 3'h6)
					begin
						bus.scl <= 1'b0;
						done <= 1'b1;
						st <= H_IDLE;
					end
				default:
					st <= H_IDLE;
			endcase
		end
endmodule : smc_host
`default_nettype wire

/* rtl/smc_pkg.sv */
// Notes on behaviour
// - fuse read always allowed, one byte returned
// - fuse write only with secure code, no data
// - fuses blow in order; all blown cancels
// - fuse write runs nonvolatile cycle; never unblows
// - reset plus clock gives 32-bit answer, LSB first
// - reset revokes password and authentication rights
// - host sends selector nibble and three password bytes
// - password check ends with counter write cycle
// - host polls with B5 then counter address; the tb poll sends B5 alone, no address
// - good password sets FF, bad clears one bit
// - init auth seeds generator, clears one counter bit
// - host polls with B7 after init auth
// - challenge equal cryptogram+1 stores cryptogram+2
// - valid auth sets FF, invalid still cycles
// - data changes only while clock low; device starts driving ATR_VALUE[0] while the reset pulse holds the clock high
// - falling data with clock high is start
// - rising data with clock high is stop, standby
// - bytes of eight bits, device acks ninth clock
// - host acks reads; missing ack ends read
// - standby at power-up and after finished stop
// - busy cycle ignores inputs, poll acked after
// - host holds clock low while idle
// - bytes travel most significant bit first
// - exhausted counter blocks further attempts
package smc_pkg;
	localparam logic [7:0] CMD_READ_CFG   = 8'hb5;
	localparam logic [7:0] CMD_VERIFY_PW  = 8'hb3;
	localparam logic [7:0] CMD_INIT_AUTH  = 8'hb6;
	localparam logic [7:0] CMD_VERIFY_AUTH = 8'hb7;
	localparam logic [7:0] CMD_FUSE_RD    = 8'hb9;
	localparam logic [7:0] CMD_FUSE_WR    = 8'hba;
	localparam logic [3:0] SEL_SECURE     = 4'h7;
	localparam logic [7:0] CNT_FULL       = 8'hff;
	localparam logic [7:0] CNT_DEAD       = 8'h00;
	localparam logic [7:0] PW_CNT_BASE_ADDR = 8'h60;
	localparam logic [7:0] AUTH_CNT_ADDR    = 8'h50;
	localparam int         ATR_BITS       = 32;
	localparam int         CLK_HZ         = 10_000_000;
	localparam int         T_WR_MS        = 10;
	localparam int         T_WR_CYCLES    = CLK_HZ / 1000 * T_WR_MS;
	localparam int         SCL_HALF       = 5;
	localparam logic [2:0] FUSES_RESET    = 3'h7;
endpackage : smc_pkg

/* verification/secure_memory_command_protocol_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module secure_memory_command_protocol_tb;
	localparam logic [31:0] ATR = 32'h5a_c3_96_0f;  // arbitrary
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        go = 1'b0;
	logic [7:0]  cmd = 8'h00;
	logic [7:0]  data [0:8];
	logic [3:0]  nbytes = 4'h1;
	logic        do_read = 1'b0;
	logic        do_atr = 1'b0;
	logic        done, nacked, standby, busy, auth_ok, pw_ok;
	logic [31:0] rx;
	logic [2:0]  fuses;
	int          n_mismatch = 0;
	int          num_checks = 0;

	smc_bus_if bus ();
	// short write cycle, still longer than one command byte so a poll can see it
	smc_device #(.T_WR(400), .ATR_VALUE(ATR)) smc_device_i (.clk(clk), .rst(rst), .bus(bus.dev),
		.standby(standby), .busy(busy), .fuses(fuses), .auth_ok(auth_ok), .pw_ok(pw_ok));
	smc_host smc_host_i (.clk(clk), .rst(rst), .bus(bus.host), .go(go), .cmd(cmd), .data(data),
		.nbytes(nbytes), .do_read(do_read), .do_atr(do_atr), .done(done), .nacked(nacked), .rx(rx));
	smc_assertions smc_assertions_i (.clk(clk), .rst(rst), .scl(bus.scl), .rst_pin(bus.rst_pin),
		.sda_host_o(bus.sda_host_o), .sda_host_oe(bus.sda_host_oe), .sda_dev_o(bus.sda_dev_o),
		.sda_dev_oe(bus.sda_dev_oe), .sda(bus.sda));

	always #50 clk = ~clk;

	// ****************************************
	// shared tasks
	// ****************************************
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task run(input logic [7:0] c, input logic [3:0] n, input logic r, input logic a);
		int k;
		go <= 1'b1;
		cmd <= c;
		nbytes <= n;
		do_read <= r;
		do_atr <= a;
		@(posedge clk);
		go <= 1'b0;
		for (k = 0; k < 20000 && done !== 1'b1; k++)
			@(negedge clk);
		chk("done", 32'h1, {31'h0, done});
		@(posedge clk);
	endtask : run

	task poll(input logic [7:0] a, input logic b);
		int k;
		run(a, 4'h1, 1'b0, 1'b0);
		chk("first poll nack", {31'h0, b}, {31'h0, nacked});
		for (k = 0; k < 40 && nacked !== 1'b0; k++)
			run(a, 4'h1, 1'b0, 1'b0);
		chk("poll ack", 32'h0, {31'h0, nacked});
	endtask : poll

	// ****************************************
	// scenarios
	// ****************************************
	task t_reset;
		chk("standby", 32'h1, {31'h0, standby});
		chk("fuses", 32'h7, {29'h0, fuses});
		chk("pw_ok", 32'h0, {31'h0, pw_ok});
		chk("auth_ok", 32'h0, {31'h0, auth_ok});
	endtask : t_reset

	task t_fuse_read;
		run(smc_pkg::CMD_FUSE_RD, 4'h1, 1'b1, 1'b0);
		chk("fuse byte", 32'h7, {29'h0, rx[2:0]});
		chk("standby after read", 32'h1, {31'h0, standby});
	endtask : t_fuse_read

	task t_fuse_denied;
		run(smc_pkg::CMD_FUSE_WR, 4'h1, 1'b0, 1'b0);
		chk("fuses locked", 32'h7, {29'h0, fuses});
		chk("busy after denied", 32'h0, {31'h0, busy});
	endtask : t_fuse_denied

	task t_password(input logic [7:0] b, input logic exp);
		data[0] <= {4'h0, smc_pkg::SEL_SECURE};
		data[1] <= b;
		data[2] <= 8'h00;
		data[3] <= 8'h00;
		run(smc_pkg::CMD_VERIFY_PW, 4'h5, 1'b0, 1'b0);
		poll(smc_pkg::CMD_READ_CFG, 1'b1);
		chk("pw_ok", {31'h0, exp}, {31'h0, pw_ok});
	endtask : t_password

	task t_fuses;
		for (int i = 0; i < 4; i++)
		begin
			run(smc_pkg::CMD_FUSE_WR, 4'h1, 1'b0, 1'b0);
			poll(smc_pkg::CMD_READ_CFG, i < 3);
			chk("fuses intact", 32'((i < 3) ? 2 - i : 0), 32'($countones(fuses)));
		end
	endtask : t_fuses

	task t_atr;
		run(8'h00, 4'h1, 1'b0, 1'b1);
		chk("atr word", ATR, rx);
		chk("pw after atr", 32'h0, {31'h0, pw_ok});
		chk("fuses stay blown", 32'h0, {29'h0, fuses});
	endtask : t_atr

	task t_auth;
		for (int i = 0; i < 8; i++)
			data[i] <= 8'h11;
		run(smc_pkg::CMD_INIT_AUTH, 4'h9, 1'b0, 1'b0);
		poll(smc_pkg::CMD_VERIFY_AUTH, 1'b1);
		run(smc_pkg::CMD_VERIFY_AUTH, 4'h9, 1'b0, 1'b0);
		poll(smc_pkg::CMD_READ_CFG, 1'b1);
		chk("auth_ok", 32'h0, {31'h0, auth_ok});
		run(smc_pkg::CMD_INIT_AUTH, 4'h9, 1'b0, 1'b0);
		poll(smc_pkg::CMD_VERIFY_AUTH, 1'b1);
		for (int i = 0; i < 8; i++)
			data[i] <= 8'(i == 7);
		run(smc_pkg::CMD_VERIFY_AUTH, 4'h9, 1'b0, 1'b0);
		poll(smc_pkg::CMD_READ_CFG, 1'b1);
		chk("auth_ok valid", 32'h1, {31'h0, auth_ok});
	endtask : t_auth

	task results;
		if (n_mismatch == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : results

	// ****************************************
	// main sequence and watchdog
	// ****************************************
	initial
	begin
		for (int i = 0; i < 9; i++)
			data[i] = 8'h00;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset;
		t_fuse_read;
		t_fuse_denied;
		t_password(8'h00, 1'b1);
		t_fuses;
		t_atr;
		t_password(8'h5a, 1'b0);
		t_auth;
		results;
	end

	initial
	begin
		repeat (60000) @(posedge clk);
		n_mismatch++;
		results;
	end
endmodule : secure_memory_command_protocol_tb
`default_nettype wire

/* verification/smc_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module smc_assertions (
	input wire logic clk,
	input wire logic rst,
	input wire logic scl,
	input wire logic rst_pin,
	input wire logic sda_host_o,
	input wire logic sda_host_oe,
	input wire logic sda_dev_o,
	input wire logic sda_dev_oe,
	input wire logic sda
);
	// ****************************************
	// bit position since the last start
	// ****************************************
	logic [3:0] bitn;

	// saturates so a long read or an answer-to-reset never wraps into the command byte
	always_ff @(posedge clk or posedge rst)
		if (rst)
			bitn <= 4'hf;
		else if (scl && $fell(sda))
			bitn <= 4'h0;
		else if (scl && $rose(sda))
			bitn <= 4'hf;
		else if ($rose(scl) && bitn != 4'hf)
			bitn <= bitn + 4'h1;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// ****************************************
	// properties
	// ****************************************
	sequence s_start;
		scl && $fell(sda);
	endsequence
	sequence s_stop;
		scl && $rose(sda);
	endsequence
	sequence s_clock_low;
		##[1:40] !scl;
	endsequence

	property p_dev_stable;
		scl && $past(scl) |-> $stable(sda_dev_oe && !sda_dev_o);
	endproperty
	property p_start_quiet;
		s_start |-> !(sda_dev_oe && !sda_dev_o);
	endproperty
	property p_stop_quiet;
		s_stop |-> !(sda_dev_oe && !sda_dev_o);
	endproperty
	property p_cmd_host_only;
		$rose(scl) && bitn < 4'h8 |-> !(sda_dev_oe && !sda_dev_o);
	endproperty
	property p_stop_then_low;
		s_stop |-> s_clock_low;
	endproperty
	property p_start_then_clock;
		s_start |-> s_clock_low ##[1:40] scl;
	endproperty
	property p_no_contention;
		!(sda_host_oe && sda_dev_oe);
	endproperty
	property p_scl_high_width;
		$rose(scl) |-> scl[*2];
	endproperty

	a_dev_stable: assert property (p_dev_stable)
		else $error("device moved sda while scl high");
	a_start_quiet: assert property (p_start_quiet)
		else $error("device drove sda at a start");
	a_stop_quiet: assert property (p_stop_quiet)
		else $error("device held sda low at a stop");
	a_cmd_host_only: assert property (p_cmd_host_only)
		else $error("device drove sda inside the command byte");
	a_stop_then_low: assert property (p_stop_then_low)
		else $error("scl not parked low after stop");
	a_start_then_clock: assert property (p_start_then_clock)
		else $error("no clocking after start");
	a_no_contention: assert property (p_no_contention)
		else $error("host and device drive sda together");
	a_scl_high_width: assert property (p_scl_high_width)
		else $error("scl high phase too short");
endmodule : smc_assertions
`default_nettype wire
